// ---- src/anps_pkg.sv ----
// Package for the auto-negotiation next-page status register bank.
// Assumes a 32-bit Avalon-MM slave with word-aligned registers.
package anps_pkg;
    // Printed management indices; byte address is four times the index
    localparam logic [7:0]  IDX_PARTNER_PAGE  = 8'h05;
    localparam logic [7:0]  IDX_EXPANSION     = 8'h06;
    localparam logic [7:0]  IDX_IRQ_STATUS    = 8'h20;
    localparam logic [7:0]  IDX_IRQ_MASK      = 8'h21;
    localparam logic [7:0]  IDX_PAGE_CTRL     = 8'h22;
    // Bit positions of the partner next-page word
    localparam int          NP_MSG_BIT        = 13;
    localparam int          NP_COMPLY_BIT     = 12;
    localparam int          NP_TOGGLE_BIT     = 11;
    localparam int          NP_CODE_W         = 11;
    localparam int          NP_ACK_BIT        = 14;
    localparam int          NP_NEXT_BIT       = 15;
    // Bit positions of the expansion register
    localparam int          EXP_PDF_BIT       = 4;
    localparam int          EXP_LP_NP_BIT     = 3;
    localparam int          EXP_LOC_NP_BIT    = 2;
    localparam int          EXP_PAGE_BIT      = 1;
    localparam int          EXP_LP_AN_BIT     = 0;
    localparam int          EXP_USED_W        = 5;
    // Reset values
    localparam logic [15:0] NP_WORD_RESET     = 16'h0000;
    localparam logic [4:0]  EXP_RESET         = 5'h04;
    localparam logic [2:0]  IRQ_MASK_RESET    = 3'h0;
    localparam int          IRQ_W             = 3;
    // Interrupt status bits
    localparam int          IRQ_PAGE_BIT      = 0;
    localparam int          IRQ_PDF_BIT       = 1;
    localparam int          IRQ_PARTNER_BIT   = 2;
    localparam logic [31:0] UNMAPPED_READ     = 32'h0000_0000;
endpackage : anps_pkg

// ---- src/anps_regs.sv ----
// Auto-negotiation next-page status registers behind an Avalon-MM slave.
// Assumes the auto-negotiation engine on CORE_CLK delivers page strobes.
// Operation
// R1: The acknowledge bit of the partner page word is set only by the negotiation engine.
// R2: Bit 13 reports message page (1) or unformatted page (0) for the code field.
// R3: Bit 12 reports whether the partner can comply with the next-page message.
// R4: Bit 11 reads 1 when the previous link code word toggle was 0, else 0.
// R5: The 11-bit code field is read-only and resets to zero.
// R6: The expansion register sits at index 06h with bits 15:5 reading zero, writes ignored.
// R7: Expansion bit 4 shows a parallel detection fault, resets 0, read-only.
// R8: Expansion bit 3 shows partner next-page support, resets 0, read-only.
// R9: Expansion bit 2 always reads 1 and writes do not change it.
// R10: Expansion bit 1 is set on page reception and cleared by a read.
// R11: Expansion bit 0 shows partner auto-negotiation support, resets 0, read-only.
// R12: The partner page word sits at index 05h.
// R13: Both registers are 16 bits and a read returns page-received before its clear.
//
// The Avalon-MM register port is this design's own decision.
module anps_regs (
    input  wire logic        CORE_CLK,
    input  wire logic        SYS_RST,
    input  wire logic [9:0]  AVS_ADDRESS,
    input  wire logic        AVS_READ,
    input  wire logic        AVS_WRITE,
    input  wire logic [31:0] AVS_WRITEDATA,
    input  wire logic [3:0]  AVS_BYTEENABLE,
    output logic      [31:0] AVS_READDATA,
    output logic             AVS_WAITREQUEST,
    input  wire logic        PAGE_RX_STROBE,
    input  wire logic [15:0] PAGE_RX_WORD,
    input  wire logic        PARALLEL_DETECT_FAULT,
    input  wire logic        PARTNER_EXTRA_PAGE_CAPABLE,
    input  wire logic        PARTNER_AUTONEG_CAPABLE,
    output logic             PAGE_VIEW_NEXT,
    output logic             IRQ
);
    logic [15:0] np_word_q, np_word_d;
    logic [4:0]  exp_q, exp_d;
    logic [2:0]  irq_stat_q, irq_stat_d;
    logic [2:0]  irq_mask_q, irq_mask_d;
    logic        view_q, view_d;
    logic        ack_q, ack_d;
    logic [31:0] rdata_q, rdata_d;
    logic        pdf_prev_q, pdf_prev_d;
    logic        an_prev_q, an_prev_d;
    logic [7:0]  idx;
    logic        rd_go;
    logic        wr_go;
    logic [15:0] exp_view;

    assign idx   = AVS_ADDRESS[9:2];
    assign rd_go = AVS_READ & ~ack_q;
    assign wr_go = AVS_WRITE & ~ack_q;
    assign AVS_WAITREQUEST = (AVS_READ | AVS_WRITE) & ~ack_q;
    assign AVS_READDATA    = rdata_q;
    assign PAGE_VIEW_NEXT  = view_q;
    assign IRQ             = |(irq_stat_q & irq_mask_q);
    assign exp_view        = {11'h000, exp_q}; // R6

    // Bus handshake: exactly one wait cycle per request
    always_comb begin
        ack_d = rd_go | wr_go;
    end

    always_ff @(posedge CORE_CLK) begin
        if (SYS_RST) begin
            ack_q <= 1'b0;
        end else begin
            ack_q <= ack_d;
        end
    end

    AST_ONE_WAIT: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
        (AVS_READ || AVS_WRITE) && AVS_WAITREQUEST |=> !AVS_WAITREQUEST)
        else $error("waitrequest longer than one cycle");
    AST_FIRST_WAIT: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
        ((AVS_READ || AVS_WRITE) && !ack_q)
        |-> AVS_WAITREQUEST)
        else $error("request not held for a wait cycle");
    AST_IDLE_WAIT: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
        !(AVS_READ || AVS_WRITE)
        |-> !AVS_WAITREQUEST)
        else $error("waitrequest without request");
    AST_ACK_ONE: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
        ack_q
        |=> !ack_q)
        else $error("acknowledge longer than one cycle");

    // Read data, held until the next read completes
    always_comb begin
        rdata_d = rdata_q;
        if (rd_go) begin
            case (idx)
                anps_pkg::IDX_PARTNER_PAGE: rdata_d = {16'h0000, np_word_q}; // R12 R13
                anps_pkg::IDX_EXPANSION:    rdata_d = {16'h0000, exp_view}; // R6 R13
                anps_pkg::IDX_IRQ_STATUS:   rdata_d = {29'h0, irq_stat_q};
                anps_pkg::IDX_IRQ_MASK:     rdata_d = {29'h0, irq_mask_q};
                anps_pkg::IDX_PAGE_CTRL:    rdata_d = {31'h0, view_q};
                default:                    rdata_d = anps_pkg::UNMAPPED_READ;
            endcase
        end
    end

    always_ff @(posedge CORE_CLK) begin
        if (SYS_RST) begin
            rdata_q <= 32'h0000_0000;
        end else begin
            rdata_q <= rdata_d;
        end
    end

    AST_RSVD_ZERO: assert property (@(posedge CORE_CLK) disable iff (SYS_RST) // R6
        (ack_q && $past(rd_go) && $past(idx) == anps_pkg::IDX_EXPANSION)
        |-> rdata_q[15:5] == 11'h000) else $error("reserved bits not zero");
    AST_PAGE_RD: assert property (@(posedge CORE_CLK) disable iff (SYS_RST) // R13
        (rd_go && idx == anps_pkg::IDX_EXPANSION)
        |=> rdata_q[anps_pkg::EXP_PAGE_BIT] == $past(exp_q[anps_pkg::EXP_PAGE_BIT]))
        else $error("read lost page flag");
    AST_WORD_RD: assert property (@(posedge CORE_CLK) disable iff (SYS_RST) // R12
        (rd_go && idx == anps_pkg::IDX_PARTNER_PAGE) |=> rdata_q[15:0] == $past(np_word_q))
        else $error("page word read wrong");
    AST_RD_HIGH: assert property (@(posedge CORE_CLK) disable iff (SYS_RST) // R13
        (rd_go && (idx == anps_pkg::IDX_PARTNER_PAGE || idx == anps_pkg::IDX_EXPANSION))
        |=> rdata_q[31:16] == 16'h0000)
        else $error("upper read half not zero");
    AST_RDATA_HOLD: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
        !rd_go
        |=> $stable(rdata_q))
        else $error("read data changed without read");
    AST_UNMAPPED: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
        (rd_go && idx > anps_pkg::IDX_PAGE_CTRL)
        |=> rdata_q == anps_pkg::UNMAPPED_READ)
        else $error("unmapped read not zero");
    AST_RD_IRQ: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
        (rd_go && idx == anps_pkg::IDX_IRQ_STATUS)
        |=> rdata_q == {29'h0, $past(irq_stat_q)})
        else $error("status read wrong");
    AST_RD_MASK: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
        (rd_go && idx == anps_pkg::IDX_IRQ_MASK)
        |=> rdata_q == {29'h0, $past(irq_mask_q)})
        else $error("mask read wrong");

    // Page word fields only come from the engine; no write path
    always_comb begin
        np_word_d = np_word_q;
        if (PAGE_RX_STROBE) begin
            np_word_d = PAGE_RX_WORD; // R1 R2 R3 R4 R5
        end
    end

    always_ff @(posedge CORE_CLK) begin
        if (SYS_RST) begin
            np_word_q <= anps_pkg::NP_WORD_RESET; // R5
        end else begin
            np_word_q <= np_word_d;
        end
    end

    AST_WORD_HOLD: assert property (@(posedge CORE_CLK) disable iff (SYS_RST) // R1
        !PAGE_RX_STROBE |=> $stable(np_word_q)) else $error("page word changed without page");
    AST_WORD_LOAD: assert property (@(posedge CORE_CLK) disable iff (SYS_RST) // R2
        PAGE_RX_STROBE |=> np_word_q == $past(PAGE_RX_WORD)) else $error("page word not loaded");
    AST_ACK_NOWR: assert property (@(posedge CORE_CLK) disable iff (SYS_RST) // R1
        (wr_go && idx == anps_pkg::IDX_PARTNER_PAGE && !PAGE_RX_STROBE)
        |=> np_word_q == $past(np_word_q))
        else $error("page word changed by write");

    // Expansion bits; any read clears page-received, a new page wins
    always_comb begin
        exp_d = exp_q;
        exp_d[anps_pkg::EXP_PDF_BIT]    = PARALLEL_DETECT_FAULT; // R7
        exp_d[anps_pkg::EXP_LP_NP_BIT]  = PARTNER_EXTRA_PAGE_CAPABLE; // R8
        exp_d[anps_pkg::EXP_LOC_NP_BIT] = 1'b1; // R9
        exp_d[anps_pkg::EXP_LP_AN_BIT]  = PARTNER_AUTONEG_CAPABLE; // R11
        if (rd_go) begin
            exp_d[anps_pkg::EXP_PAGE_BIT] = 1'b0; // R10
        end
        if (PAGE_RX_STROBE) begin
            exp_d[anps_pkg::EXP_PAGE_BIT] = 1'b1; // R10
        end
    end

    always_ff @(posedge CORE_CLK) begin
        if (SYS_RST) begin
            exp_q <= anps_pkg::EXP_RESET;
        end else begin
            exp_q <= exp_d;
        end
    end

    AST_LOCAL_NP: assert property (@(posedge CORE_CLK) disable iff (SYS_RST) // R9
        exp_q[anps_pkg::EXP_LOC_NP_BIT]) else $error("local next-page bit not 1");
    AST_PAGE_SET: assert property (@(posedge CORE_CLK) disable iff (SYS_RST) // R10
        PAGE_RX_STROBE |=> exp_q[anps_pkg::EXP_PAGE_BIT]) else $error("page flag not set");
    AST_PAGE_CLR: assert property (@(posedge CORE_CLK) disable iff (SYS_RST) // R10
        (rd_go && !PAGE_RX_STROBE) |=> !exp_q[anps_pkg::EXP_PAGE_BIT])
        else $error("page flag not cleared by read");
    AST_EXP_NOWR: assert property (@(posedge CORE_CLK) disable iff (SYS_RST) // R6
        (wr_go && idx == anps_pkg::IDX_EXPANSION && !PAGE_RX_STROBE)
        |=> exp_q[anps_pkg::EXP_PAGE_BIT] == $past(exp_q[anps_pkg::EXP_PAGE_BIT]))
        else $error("expansion changed by write");
    AST_PDF: assert property (@(posedge CORE_CLK) disable iff (SYS_RST) // R7
        ##1 exp_q[anps_pkg::EXP_PDF_BIT] == $past(PARALLEL_DETECT_FAULT))
        else $error("fault bit wrong");
    AST_LPNP: assert property (@(posedge CORE_CLK) disable iff (SYS_RST) // R8
        ##1 exp_q[anps_pkg::EXP_LP_NP_BIT] == $past(PARTNER_EXTRA_PAGE_CAPABLE))
        else $error("partner next-page bit wrong");
    AST_LPAN: assert property (@(posedge CORE_CLK) disable iff (SYS_RST) // R11
        ##1 exp_q[anps_pkg::EXP_LP_AN_BIT] == $past(PARTNER_AUTONEG_CAPABLE))
        else $error("partner autoneg bit wrong");

    // Input history for rising-edge events
    always_comb begin
        pdf_prev_d = PARALLEL_DETECT_FAULT;
        an_prev_d  = PARTNER_AUTONEG_CAPABLE;
    end

    always_ff @(posedge CORE_CLK) begin
        if (SYS_RST) begin
            pdf_prev_q <= 1'b0;
            an_prev_q  <= 1'b0;
        end else begin
            pdf_prev_q <= pdf_prev_d;
            an_prev_q  <= an_prev_d;
        end
    end

    // Sticky event status, cleared by its read; a new event wins
    always_comb begin
        irq_stat_d = irq_stat_q;
        irq_mask_d = irq_mask_q;
        if (rd_go && idx == anps_pkg::IDX_IRQ_STATUS) begin
            irq_stat_d = '0;
        end
        if (PAGE_RX_STROBE) begin
            irq_stat_d[anps_pkg::IRQ_PAGE_BIT] = 1'b1;
        end
        if (PARALLEL_DETECT_FAULT && !pdf_prev_q) begin
            irq_stat_d[anps_pkg::IRQ_PDF_BIT] = 1'b1;
        end
        if (PARTNER_AUTONEG_CAPABLE && !an_prev_q) begin
            irq_stat_d[anps_pkg::IRQ_PARTNER_BIT] = 1'b1;
        end
        if (wr_go && AVS_BYTEENABLE[0] && idx == anps_pkg::IDX_IRQ_MASK) begin
            irq_mask_d = AVS_WRITEDATA[2:0];
        end
    end

    always_ff @(posedge CORE_CLK) begin
        if (SYS_RST) begin
            irq_stat_q <= '0;
            irq_mask_q <= anps_pkg::IRQ_MASK_RESET;
        end else begin
            irq_stat_q <= irq_stat_d;
            irq_mask_q <= irq_mask_d;
        end
    end

    AST_IRQ_PAGE: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
        PAGE_RX_STROBE
        |=> irq_stat_q[anps_pkg::IRQ_PAGE_BIT])
        else $error("page event not recorded");
    AST_IRQ_PDF: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
        (PARALLEL_DETECT_FAULT && !pdf_prev_q)
        |=> irq_stat_q[anps_pkg::IRQ_PDF_BIT])
        else $error("fault event not recorded");
    AST_IRQ_AN: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
        (PARTNER_AUTONEG_CAPABLE && !an_prev_q)
        |=> irq_stat_q[anps_pkg::IRQ_PARTNER_BIT])
        else $error("partner event not recorded");
    AST_IRQ_CLR: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
        (rd_go && idx == anps_pkg::IDX_IRQ_STATUS && !PAGE_RX_STROBE)
        |=> !irq_stat_q[anps_pkg::IRQ_PAGE_BIT])
        else $error("status not cleared by read");
    AST_IRQ_STICKY: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
        !(rd_go && idx == anps_pkg::IDX_IRQ_STATUS)
        |=> (irq_stat_q & $past(irq_stat_q)) == $past(irq_stat_q))
        else $error("status bit lost without read");
    AST_MASK_WR: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
        (wr_go && AVS_BYTEENABLE[0] && idx == anps_pkg::IDX_IRQ_MASK)
        |=> irq_mask_q == $past(AVS_WRITEDATA[2:0]))
        else $error("mask write lost");

    // Next-page view select for the rest of the transceiver
    always_comb begin
        view_d = view_q;
        if (wr_go && AVS_BYTEENABLE[0] && idx == anps_pkg::IDX_PAGE_CTRL) begin
            view_d = AVS_WRITEDATA[0];
        end
    end

    always_ff @(posedge CORE_CLK) begin
        if (SYS_RST) begin
            view_q <= 1'b0;
        end else begin
            view_q <= view_d;
        end
    end

    AST_VIEW_WR: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
        (wr_go && AVS_BYTEENABLE[0] && idx == anps_pkg::IDX_PAGE_CTRL)
        |=> PAGE_VIEW_NEXT == $past(AVS_WRITEDATA[0]))
        else $error("view select write lost");
    AST_VIEW_HOLD: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
        !(wr_go && idx == anps_pkg::IDX_PAGE_CTRL)
        |=> $stable(PAGE_VIEW_NEXT))
        else $error("view select changed without write");

    COV_PAGE: cover property (@(posedge CORE_CLK) PAGE_RX_STROBE ##[1:20] rd_go);
    COV_RACE: cover property (@(posedge CORE_CLK) PAGE_RX_STROBE && rd_go);
    COV_IRQ: cover property (@(posedge CORE_CLK) $rose(IRQ));
    COV_MASK_WR: cover property (@(posedge CORE_CLK) wr_go && idx == anps_pkg::IDX_IRQ_MASK);
    COV_PDF_RISE: cover property (@(posedge CORE_CLK) $rose(exp_q[anps_pkg::EXP_PDF_BIT]));
endmodule // anps_regs

// ---- tb/tb_anps_top.sv ----
// Self-checking bench for the next-page status register bank.
// Bench masters the Avalon-MM slave and drives engine inputs directly, one clock.
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk        = 1'b0;
    logic        rst        = 1'b1;
    logic [9:0]  adr        = '0;
    logic        rd         = 1'b0;
    logic        wr         = 1'b0;
    logic [31:0] wdat       = '0;
    logic [31:0] rdat;
    logic        wreq;
    logic        stb        = 1'b0;
    logic [15:0] word       = '0;
    logic        parallel_detect_fault        = 1'b0;
    logic        lpnp       = 1'b0;
    logic        lpan       = 1'b0;
    logic        view;
    logic        irq;
    logic [31:0] q;
    int          fail_count = 0;
    int          n_compared = 0;
    logic [15:0] words [2]  = '{16'h2955, 16'hD2AA};

    anps_regs dut (.CORE_CLK(clk), .SYS_RST(rst), .AVS_ADDRESS(adr), .AVS_READ(rd),
        .AVS_WRITE(wr), .AVS_WRITEDATA(wdat), .AVS_BYTEENABLE(4'hF), .AVS_READDATA(rdat),
        .AVS_WAITREQUEST(wreq), .PAGE_RX_STROBE(stb), .PAGE_RX_WORD(word),
        .PARALLEL_DETECT_FAULT(parallel_detect_fault), .PARTNER_EXTRA_PAGE_CAPABLE(lpnp),
        .PARTNER_AUTONEG_CAPABLE(lpan), .PAGE_VIEW_NEXT(view), .IRQ(irq));

    initial forever #5 clk = ~clk;

    task automatic test_done;
        $display("compared %0d mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            fail_count++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // One Avalon transfer; held until waitrequest is seen low
    task automatic bus(input logic w, input logic [9:0] a, input logic [31:0] d);
        int n;
        @(posedge clk);
        adr  <= a;
        wdat <= d;
        rd   <= ~w;
        wr   <= w;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (wreq !== 1'b0 && n < 20);
        q = rdat;
        rd <= 1'b0;
        wr <= 1'b0;
        if (wreq !== 1'b0) begin
            fail_count++;
            test_done();
        end
    endtask

    task automatic page(input logic [15:0] w);
        @(posedge clk);
        stb  <= 1'b1;
        word <= w;
        @(posedge clk);
        stb  <= 1'b0;
    endtask

    initial begin
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        bus(1'b0, 10'h018, '0); chk(q, 32'h0000_0004);
        bus(1'b0, 10'h014, '0); chk(q, 32'h0000_0000);
        bus(1'b1, 10'h018, 32'hFFFF_FFFF);
        bus(1'b0, 10'h018, '0); chk(q, 32'h0000_0004);
        bus(1'b0, 10'h3FC, '0); chk(q, 32'h0000_0000);
        bus(1'b1, 10'h088, 32'h0000_0001);
        bus(1'b1, 10'h084, 32'h0000_0001);
        chk({31'h0, view}, 32'h0000_0001);
        foreach (words[i]) begin
            page(words[i]);
            bus(1'b1, 10'h014, {16'h0000, ~words[i]});
            @(negedge clk); chk({31'h0, irq}, 32'h0000_0001);
            bus(1'b0, 10'h018, '0); chk(q, 32'h0000_0006);
            bus(1'b0, 10'h018, '0); chk(q, 32'h0000_0004);
            bus(1'b0, 10'h014, '0); chk(q, {16'h0000, words[i]});
            bus(1'b0, 10'h080, '0); chk(q, 32'h0000_0001);
            @(negedge clk); chk({31'h0, irq}, 32'h0000_0000);
        end
        @(posedge clk);
        parallel_detect_fault  <= 1'b1;
        lpnp <= 1'b1;
        lpan <= 1'b1;
        repeat (3) @(posedge clk);
        bus(1'b0, 10'h018, '0); chk(q, 32'h0000_001D);
        @(negedge clk); chk({31'h0, irq}, 32'h0000_0000);
        bus(1'b0, 10'h080, '0); chk(q, 32'h0000_0006);
        parallel_detect_fault  <= 1'b0;
        lpnp <= 1'b0;
        lpan <= 1'b0;
        repeat (3) @(posedge clk);
        bus(1'b0, 10'h018, '0); chk(q, 32'h0000_0004);
        fork
            page(16'h8001);
            bus(1'b0, 10'h080, '0);
        join
        chk(q, 32'h0000_0000);
        bus(1'b0, 10'h018, '0); chk(q, 32'h0000_0006);
        bus(1'b0, 10'h080, '0); chk(q, 32'h0000_0001);
        bus(1'b0, 10'h014, '0); chk(q, 32'h0000_8001);
        test_done();
    end
endmodule // tb_top
